// ### hw/pfc_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - After completion, reread twice about 1 us later before trusting the full byte.
// - Every byte program is preceded by the three-write unlock sequence.
// - Every erase is preceded by the five-write unlock sequence.
// - The identification exit sequence returns the device to array reads.
// - Sector erase ends with code 30H at the sector address.
// - Chip erase ends with code 10H at address 5555H.
module pfc_ctrl #(
  parameter int SETTLE_CYCLES = pfc_pkg::SETTLE_CYC,
  parameter int POLL_LIMIT = 100000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic req_valid,
  input pfc_pkg::pfc_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [pfc_pkg::DATA_W-1:0] rsp_data,
  output logic rsp_error,
  input wire logic [pfc_pkg::DATA_W-1:0] dq_in,
  output logic [pfc_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  output logic [pfc_pkg::ADDR_W-1:0] addr,
  output logic ce_n,
  output logic oe_n,
  output logic we_n
);

  // ----------------------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------------------
  logic [pfc_pkg::DATA_W-1:0] dq_meta_ff, dq_sync_ff;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      dq_meta_ff <= '0;
      dq_sync_ff <= '0;
    end else begin
      dq_meta_ff <= dq_in;
      dq_sync_ff <= dq_meta_ff;
    end
  end

  // ----------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PFC_IDLE, PFC_WRITE, PFC_READ, PFC_POLL, PFC_SETTLE, PFC_CONFIRM, PFC_DONE
  } pfc_st_t;

  pfc_st_t st_ff, nxt_st;
  pfc_pkg::pfc_req_t req_ff, nxt_req;
  logic [2:0] step_ff, nxt_step;
  logic [2:0] nwr_ff, nxt_nwr;
  logic [31:0] cnt_ff, nxt_cnt;
  logic [1:0] conf_ff, nxt_conf;
  logic [pfc_pkg::DATA_W-1:0] last_ff, nxt_last;
  logic busy_ff, nxt_busy;
  logic rdy_ff, nxt_rdy;
  logic rv_ff, nxt_rv;
  logic [pfc_pkg::DATA_W-1:0] rd_ff, nxt_rd;
  logic err_ff, nxt_err;

  logic cyc_start, cyc_write, cyc_done;
  logic [pfc_pkg::ADDR_W-1:0] cyc_addr;
  logic [pfc_pkg::DATA_W-1:0] cyc_data, cyc_rdata;
  pfc_pkg::pfc_pins_t cyc_pins;

  // Writes of each command sequence; high address bits are zero in unlock cycles.
  function automatic logic [pfc_pkg::ADDR_W+pfc_pkg::DATA_W-1:0] seq_word(
    input pfc_pkg::pfc_req_t r, input logic [2:0] step);
    logic [14:0] a;
    logic [7:0] d;
    a = (step == 3'd1 || step == 3'd4) ? pfc_pkg::UNLOCK_ADDR_B : pfc_pkg::UNLOCK_ADDR_A;
    d = (step == 3'd1 || step == 3'd4) ? pfc_pkg::UNLOCK_DATA_B : pfc_pkg::UNLOCK_DATA_A;
    if (step == 3'd2) begin
      unique case (r.op)
        pfc_pkg::PFC_OP_PROGRAM: d = pfc_pkg::CMD_PROGRAM;
        pfc_pkg::PFC_OP_ID_READ: d = pfc_pkg::CMD_ID_ENTRY;
        pfc_pkg::PFC_OP_ID_EXIT_LONG: d = pfc_pkg::CMD_ID_EXIT;
        default: d = pfc_pkg::CMD_ERASE_SETUP;
      endcase
    end
    seq_word = {{(pfc_pkg::ADDR_W-15){1'b0}}, a, d};
    if (r.op == pfc_pkg::PFC_OP_PROGRAM && step == 3'd3) begin
      seq_word = {r.addr, r.data};
    end
    if (r.op == pfc_pkg::PFC_OP_SECTOR_ERASE && step == 3'd5) begin
      // Only the sector bits matter to the device; low bits are sent as zero.
      seq_word = {r.addr[pfc_pkg::ADDR_W-1:pfc_pkg::SECTOR_LSB],
                  {pfc_pkg::SECTOR_LSB{1'b0}}, pfc_pkg::CMD_SECTOR_ERASE};
    end
    if (r.op == pfc_pkg::PFC_OP_CHIP_ERASE && step == 3'd5) begin
      seq_word = {{(pfc_pkg::ADDR_W-15){1'b0}}, pfc_pkg::UNLOCK_ADDR_A, pfc_pkg::CMD_CHIP_ERASE};
    end
    if (r.op == pfc_pkg::PFC_OP_ID_EXIT_SHORT) begin
      seq_word = {{pfc_pkg::ADDR_W{1'b0}}, pfc_pkg::CMD_ID_EXIT};
    end
  endfunction

  // Number of writes each operation needs.
  function automatic logic [2:0] seq_len(input pfc_pkg::pfc_op_t op);
    unique case (op)
      pfc_pkg::PFC_OP_PROGRAM: seq_len = 3'd4;
      pfc_pkg::PFC_OP_SECTOR_ERASE, pfc_pkg::PFC_OP_CHIP_ERASE: seq_len = 3'd6;
      pfc_pkg::PFC_OP_ID_READ, pfc_pkg::PFC_OP_ID_EXIT_LONG: seq_len = 3'd3;
      pfc_pkg::PFC_OP_ID_EXIT_SHORT: seq_len = 3'd1;
      default: seq_len = 3'd0;
    endcase
  endfunction

  logic erase_op;
  assign erase_op = req_ff.op == pfc_pkg::PFC_OP_SECTOR_ERASE || req_ff.op == pfc_pkg::PFC_OP_CHIP_ERASE;

  // Poll result is trusted only when the top bit matches and bit six stopped flipping.
  logic poll_ok;
  always_comb begin
    poll_ok = cyc_rdata[pfc_pkg::ALT_BIT] == last_ff[pfc_pkg::ALT_BIT];
    if (erase_op) begin
      poll_ok = poll_ok && cyc_rdata[pfc_pkg::POLL_BIT];
    end else begin
      poll_ok = poll_ok && (cyc_rdata[pfc_pkg::POLL_BIT] == req_ff.data[pfc_pkg::POLL_BIT]);
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_req = req_ff;
    nxt_step = step_ff;
    nxt_nwr = nwr_ff;
    nxt_cnt = cnt_ff;
    nxt_conf = conf_ff;
    nxt_last = last_ff;
    nxt_busy = busy_ff;
    nxt_rdy = 1'b0;
    nxt_rv = 1'b0;
    nxt_rd = rd_ff;
    nxt_err = err_ff;
    cyc_start = 1'b0;
    cyc_write = 1'b0;
    {cyc_addr, cyc_data} = seq_word(req_ff, step_ff);
    unique case (st_ff)
      PFC_IDLE: begin
        nxt_rdy = 1'b1;
        if (req_valid && rdy_ff) begin
          nxt_rdy = 1'b0;
          nxt_req = req;
          nxt_step = '0;
          nxt_nwr = seq_len(req.op);
          nxt_st = (seq_len(req.op) == 3'd0) ? PFC_READ : PFC_WRITE;
        end
      end
      PFC_WRITE: begin
        // Each write is a full cycle; the sequence is never broken by other traffic.
        cyc_start = !busy_ff;
        cyc_write = 1'b1;
        nxt_busy = 1'b1;
        if (cyc_done) begin
          nxt_busy = 1'b0;
          nxt_step = step_ff + 3'd1;
          if (step_ff + 3'd1 == nwr_ff) begin
            nxt_cnt = '0;
            nxt_conf = '0;
            if (req_ff.op == pfc_pkg::PFC_OP_PROGRAM || erase_op) begin
              // Status is valid right after the final strobe, so polling starts at once.
              nxt_st = PFC_POLL;
            end else begin
              nxt_st = (req_ff.op == pfc_pkg::PFC_OP_ID_READ) ? PFC_READ : PFC_DONE;
            end
          end
        end
      end
      PFC_READ: begin
        cyc_start = !busy_ff;
        // ID reads are sent to address 0 or 1 as chosen by the low request bit.
        cyc_addr = (req_ff.op == pfc_pkg::PFC_OP_ID_READ)
                   ? (req_ff.addr[0] ? pfc_pkg::ID_PART_ADDR : pfc_pkg::ID_MAKER_ADDR) : req_ff.addr;
        nxt_busy = 1'b1;
        if (cyc_done) begin
          nxt_busy = 1'b0;
          nxt_rd = cyc_rdata;
          nxt_err = 1'b0;
          nxt_st = PFC_DONE;
        end
      end
      PFC_POLL, PFC_CONFIRM: begin
        // No command and no reset is issued while busy; the device would ignore it.
        cyc_start = !busy_ff;
        cyc_addr = erase_op ? req_ff.addr : req_ff.addr;
        nxt_busy = 1'b1;
        if (cyc_done) begin
          nxt_busy = 1'b0;
          nxt_last = cyc_rdata;
          nxt_cnt = cnt_ff + 32'd1;
          if (st_ff == PFC_POLL) begin
            if (poll_ok && cnt_ff != '0) begin
              nxt_cnt = '0;
              nxt_st = PFC_SETTLE;
            end else if (cnt_ff >= 32'(POLL_LIMIT)) begin
              nxt_err = 1'b1;
              nxt_rd = cyc_rdata;
              nxt_st = PFC_DONE;
            end
          end else begin
            // Two stable reads confirm the end; a mismatch means the race is real.
            nxt_conf = conf_ff + 2'd1;
            nxt_rd = cyc_rdata;
            if (!poll_ok) begin
              nxt_st = PFC_POLL;
            end else if (conf_ff == 2'd1) begin
              nxt_err = 1'b0;
              nxt_st = PFC_DONE;
            end
          end
        end
      end
      PFC_SETTLE: begin
        nxt_cnt = cnt_ff + 32'd1;
        if (cnt_ff >= 32'(SETTLE_CYCLES)) begin
          nxt_cnt = 32'd1;
          nxt_conf = '0;
          nxt_st = PFC_CONFIRM;
        end
      end
      PFC_DONE: begin
        nxt_rv = 1'b1;
        nxt_st = PFC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff <= PFC_IDLE;
      req_ff <= '0;
      step_ff <= '0;
      nwr_ff <= '0;
      cnt_ff <= '0;
      conf_ff <= '0;
      last_ff <= '0;
      busy_ff <= 1'b0;
      rdy_ff <= 1'b0;
      rv_ff <= 1'b0;
      rd_ff <= '0;
      err_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      req_ff <= nxt_req;
      step_ff <= nxt_step;
      nwr_ff <= nxt_nwr;
      cnt_ff <= nxt_cnt;
      conf_ff <= nxt_conf;
      last_ff <= nxt_last;
      busy_ff <= nxt_busy;
      rdy_ff <= nxt_rdy;
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      err_ff <= nxt_err;
    end
  end

  // ----------------------------------------------------------------------------
  // Pin cycle engine
  // ----------------------------------------------------------------------------
  pfc_cycle u_cycle (
    .clk(clk),
    .rstn(rstn),
    .start(cyc_start),
    .is_write(cyc_write),
    .addr(cyc_addr),
    .wdata(cyc_data),
    .dq_sync(dq_sync_ff),
    .pins(cyc_pins),
    .done(cyc_done),
    .rdata(cyc_rdata)
  );

  // Host drives data only while the gate is high, so it never fights the device.
  assign dq_out = cyc_pins.dout;
  assign dq_oe_n = cyc_pins.dout_oe_n;
  assign addr = cyc_pins.addr;
  assign ce_n = cyc_pins.ce_n;
  assign oe_n = cyc_pins.oe_n;
  assign we_n = cyc_pins.we_n;
  assign req_ready = rdy_ff;
  assign rsp_valid = rv_ff;
  assign rsp_data = rd_ff;
  assign rsp_error = err_ff;

endmodule

// ### hw/pfc_cycle.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// One bus cycle on the flash pins: a strobed write or a gated read
// ----------------------------------------------------------------------------
module pfc_cycle (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic is_write,
  input wire logic [pfc_pkg::ADDR_W-1:0] addr,
  input wire logic [pfc_pkg::DATA_W-1:0] wdata,
  input wire logic [pfc_pkg::DATA_W-1:0] dq_sync,
  output pfc_pkg::pfc_pins_t pins,
  output logic done,
  output logic [pfc_pkg::DATA_W-1:0] rdata
);

  typedef enum logic [1:0] {PFC_C_IDLE, PFC_C_SETUP, PFC_C_STROBE, PFC_C_HOLD} pfc_cst_t;

  pfc_cst_t st_ff, nxt_st;
  logic [pfc_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic wr_ff, nxt_wr;
  pfc_pkg::pfc_pins_t pins_ff, nxt_pins;
  logic done_ff, nxt_done;
  logic [pfc_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_wr = wr_ff;
    nxt_pins = pins_ff;
    nxt_done = 1'b0;
    nxt_rdata = rdata_ff;
    unique case (st_ff)
      PFC_C_IDLE: begin
        if (start) begin
          // Address and data are set up with every strobe high so no stray write can start.
          nxt_wr = is_write;
          nxt_pins.addr = addr;
          nxt_pins.dout = wdata;
          nxt_pins.dout_oe_n = ~is_write;
          nxt_pins.ce_n = 1'b1;
          nxt_pins.oe_n = 1'b1;
          nxt_pins.we_n = 1'b1;
          nxt_cnt = pfc_pkg::CNT_W'(pfc_pkg::SETUP_CYC);
          nxt_st = PFC_C_SETUP;
        end
      end
      PFC_C_SETUP: begin
        nxt_cnt = cnt_ff - 1'b1;
        if (cnt_ff == '0) begin
          nxt_pins.ce_n = 1'b0;
          // Writes keep the output gate high; a low gate would inhibit the write.
          nxt_pins.we_n = ~wr_ff;
          nxt_pins.oe_n = wr_ff;
          // Strobe is held well past 5 ns so the device never filters it away.
          nxt_cnt = pfc_pkg::CNT_W'(wr_ff ? pfc_pkg::STROBE_CYC : pfc_pkg::ACCESS_CYC);
          nxt_st = PFC_C_STROBE;
        end
      end
      PFC_C_STROBE: begin
        nxt_cnt = cnt_ff - 1'b1;
        if (cnt_ff == '0) begin
          if (!wr_ff) begin
            nxt_rdata = dq_sync;
          end
          nxt_pins.we_n = 1'b1;
          nxt_pins.oe_n = 1'b1;
          nxt_pins.ce_n = 1'b1;
          nxt_cnt = pfc_pkg::CNT_W'(pfc_pkg::HOLD_CYC);
          nxt_st = PFC_C_HOLD;
        end
      end
      PFC_C_HOLD: begin
        nxt_cnt = cnt_ff - 1'b1;
        if (cnt_ff == '0) begin
          // Data is released only after the hold count; the device latched it on the strobe's rise.
          nxt_pins.dout_oe_n = 1'b1;
          nxt_done = 1'b1;
          nxt_st = PFC_C_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff <= PFC_C_IDLE;
      cnt_ff <= '0;
      wr_ff <= 1'b0;
      pins_ff <= '{addr: '0, dout: '0, dout_oe_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      done_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      wr_ff <= nxt_wr;
      pins_ff <= nxt_pins;
      done_ff <= nxt_done;
      rdata_ff <= nxt_rdata;
    end
  end

  assign pins = pins_ff;
  assign done = done_ff;
  assign rdata = rdata_ff;

endmodule

// ### hw/pfc_pkg.sv
package pfc_pkg;

  // ----------------------------------------------------------------------------
  // Pin bus geometry and command codes
  // ----------------------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int SECTOR_LSB = 12;
  localparam int POLL_BIT = 7;
  localparam int ALT_BIT = 6;

  localparam logic [14:0] UNLOCK_ADDR_A = 15'h5555;
  localparam logic [14:0] UNLOCK_ADDR_B = 15'h2aaa;
  localparam logic [7:0] UNLOCK_DATA_A = 8'haa;
  localparam logic [7:0] UNLOCK_DATA_B = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0] CMD_ID_EXIT = 8'hf0;
  localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 19'h00000;
  localparam logic [ADDR_W-1:0] ID_PART_ADDR = 19'h00001;

  // ----------------------------------------------------------------------------
  // Pin timing at 100 MHz
  // ----------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETUP_NS = 20;
  localparam int STROBE_NS = 40;
  localparam int HOLD_NS = 20;
  localparam int ACCESS_NS = 70;
  localparam int SETTLE_NS = 1000;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  typedef enum logic [2:0] {
    PFC_OP_READ,
    PFC_OP_PROGRAM,
    PFC_OP_SECTOR_ERASE,
    PFC_OP_CHIP_ERASE,
    PFC_OP_ID_READ,
    PFC_OP_ID_EXIT_SHORT,
    PFC_OP_ID_EXIT_LONG
  } pfc_op_t;

  typedef struct packed {
    pfc_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pfc_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic dout_oe_n;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } pfc_pins_t;

endpackage

// ### sim/pfc_ctrl_asserts.sv
`timescale 1ns/1ps
module pfc_ctrl_asserts #(
  parameter int SETTLE_CYCLES = 100,
  parameter int POLL_LIMIT = 100000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [pfc_pkg::DATA_W-1:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic [pfc_pkg::ADDR_W-1:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n
);
  localparam logic [22:0] W_AA = {15'h5555, 8'haa};
  localparam logic [22:0] W_55 = {15'h2aaa, 8'h55};
  localparam logic [22:0] W_80 = {15'h5555, 8'h80};
  localparam logic [22:0] W_A0 = {15'h5555, 8'ha0};
  // ----------------------------------------------------------------------------
  // History of the last five strobed writes
  // ----------------------------------------------------------------------------
  logic we_prev_ff;
  logic nxt_we_prev;
  logic [22:0] hist_ff [1:5];
  logic [22:0] nxt_hist [1:5];
  logic wfall;
  assign wfall = we_prev_ff && !we_n;
  always_comb begin
    nxt_we_prev = we_n;
    nxt_hist = hist_ff;
    if (wfall) begin
      for (int i = 5; i > 1; i--) begin
        nxt_hist[i] = hist_ff[i-1];
      end
      nxt_hist[1] = {addr[14:0], dq_out};
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      we_prev_ff <= 1'b1;
      hist_ff <= '{default: '0};
    end else begin
      we_prev_ff <= nxt_we_prev;
      hist_ff <= nxt_hist;
    end
  end
  // ----------------------------------------------------------------------------
  // Pin rules
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_write_gate: assert property (!we_n |-> !ce_n && oe_n) else $error("strobe outside select");
  chk_read_gate: assert property (!oe_n |-> we_n && dq_oe_n) else $error("gate with host driving");
  chk_strobe_width: assert property (wfall |-> !we_n [*4]) else $error("strobe too short");
  chk_data_hold: assert property (!we_n |-> $stable(dq_out) && $stable(addr) && !dq_oe_n)
    else $error("data moved in strobe");
  chk_program_unlock: assert property (wfall && {addr[14:0], dq_out} == W_A0 && hist_ff[1] != W_A0
    |-> hist_ff[1] == W_55 && hist_ff[2] == W_AA) else $error("program without unlock");
  chk_erase_unlock: assert property (wfall && dq_out inside {8'h30, 8'h10} && hist_ff[1] == W_55
    |-> hist_ff[2] == W_AA && hist_ff[3] == W_80 && hist_ff[4] == W_55 && hist_ff[5] == W_AA)
    else $error("erase without unlock");
  chk_sector_addr: assert property (wfall && dq_out == 8'h30 && hist_ff[1] == W_55 && hist_ff[3] == W_80
    |-> addr[11:0] == 12'h000) else $error("sector address bad");
  chk_chip_addr: assert property (wfall && dq_out == 8'h10 && hist_ff[1] == W_55 && hist_ff[3] == W_80
    |-> addr[14:0] == 15'h5555) else $error("chip erase address bad");
endmodule

// ### sim/pfc_flash_mdl.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Behavioural byte-wide flash seen from its pins
// ----------------------------------------------------------------------------
module pfc_flash_mdl #(
  parameter int PROG_NS = 2000,
  parameter int ERASE_NS = 5000,
  // Identification values are arbitrary.
  parameter logic [7:0] MAKER_ID = 8'h3c,
  parameter logic [7:0] PART_ID = 8'h4d
) (
  input wire logic [18:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [7:0] data_bus,
  output logic [7:0] data_drv
);
  logic [7:0] mem [logic [18:0]];
  logic [7:0] last = 8'h00;
  logic [7:0] rd = 8'h00;
  logic [18:0] wa;
  logic busy = 1'b0;
  logic erase = 1'b0;
  logic tog = 1'b0;
  logic id_mode = 1'b0;
  int step = 0;
  realtime fall_t = 1e9;
  realtime done_t = -1e9;
  wire wr_act = !ce_n && !we_n && oe_n;
  wire drive = !ce_n && !oe_n && we_n;

  function automatic logic [7:0] rd_mem(input logic [18:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction

  task automatic start_op(input logic e, input logic [7:0] d);
    busy = 1'b1;
    erase = e;
    last = d;
    fork
      begin
        #(e ? ERASE_NS : PROG_NS);
        busy = 1'b0;
        done_t = $realtime;
      end
    join_none
  endtask

  task automatic do_write(input logic [18:0] a, input logic [7:0] d);
    logic [18:0] k;
    if (busy) return;
    if (d == 8'hf0 && step == 0) begin
      id_mode = 1'b0;
      return;
    end
    case (step)
      0, 4: step = (a[14:0] == 15'h5555 && d == 8'haa) ? step + 1 : 0;
      1, 5: step = (a[14:0] == 15'h2aaa && d == 8'h55) ? step + 1 : 0;
      2: begin
        step = 0;
        if (a[14:0] == 15'h5555 && d == 8'ha0) step = 3;
        if (a[14:0] == 15'h5555 && d == 8'h80) step = 4;
        if (a[14:0] == 15'h5555 && d == 8'h90) id_mode = 1'b1;
        if (a[14:0] == 15'h5555 && d == 8'hf0) id_mode = 1'b0;
      end
      3: begin
        mem[a] = rd_mem(a) & d;
        start_op(1'b0, d);
        step = 0;
      end
      6: begin
        step = 0;
        if (d == 8'h30) begin
          for (int i = 0; i < 4096; i++) begin
            k = {a[18:12], i[11:0]};
            if (mem.exists(k)) mem.delete(k);
          end
          start_op(1'b1, 8'hff);
        end else if (d == 8'h10 && a[14:0] == 15'h5555) begin
          mem.delete();
          start_op(1'b1, 8'hff);
        end
      end
      default: step = 0;
    endcase
  endtask

  // A strobe shorter than 5 ns never reaches the sequencer; data is taken at the closing edge.
  always @(wr_act) begin
    if (wr_act) begin
      fall_t = $realtime;
      wa = addr;
    end else if ($realtime - fall_t >= 5.0) begin
      fall_t = 1e9;
      do_write(wa, data_bus);
    end
  end

  // Other bits stay wrong for 1 us after completion, so a hasty host sees bad data.
  always @(posedge drive) begin
    if (busy) tog = ~tog;
    if (busy) rd = {erase ? 1'b0 : ~last[7], tog, ~last[5:0]};
    else if (id_mode) rd = addr[0] ? PART_ID : MAKER_ID;
    else if ($realtime - done_t < 1000.0) rd = rd_mem(addr) ^ 8'h7f;
    else rd = rd_mem(addr);
  end

  assign data_drv = drive ? rd : ~rd;
endmodule

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
  // Identification values are arbitrary.
  localparam logic [7:0] MAKER = 8'h3c;
  localparam logic [7:0] PART = 8'h4d;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  pfc_pkg::pfc_req_t req = '0;
  logic req_ready, rsp_valid, rsp_error, dq_oe_n, ce_n, oe_n, we_n;
  logic [7:0] rsp_data, dq_out, mdl_dq;
  logic [18:0] addr;
  wire [7:0] bus = dq_oe_n ? mdl_dq : dq_out;
  int num_errors = 0;
  int checked = 0;

  always #5 clk = ~clk;

  pfc_ctrl #(.SETTLE_CYCLES(100), .POLL_LIMIT(200)) dut (.clk(clk), .rstn(rstn), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error),
    .dq_in(bus), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .addr(addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));
  pfc_flash_mdl #(.MAKER_ID(MAKER), .PART_ID(PART)) u_flash (.addr(addr), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .data_bus(bus), .data_drv(mdl_dq));

  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One request through the handshake; the answer is sampled in its single valid cycle.
  task automatic do_req(input pfc_pkg::pfc_op_t op, input logic [18:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic err);
    int n;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) check8(8'h00, 8'h01);
    req.op = op;
    req.addr = a;
    req.data = d;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 8000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 8000) check8(8'h00, 8'h01);
    q = rsp_data;
    err = rsp_error;
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_program();
    logic [7:0] q;
    logic e;
    do_req(pfc_pkg::PFC_OP_READ, 19'h00123, 8'h00, q, e);
    check8(q, 8'hff);
    do_req(pfc_pkg::PFC_OP_PROGRAM, 19'h00123, 8'h5a, q, e);
    check8(q, 8'h5a);
    check8({7'h00, e}, 8'h00);
    do_req(pfc_pkg::PFC_OP_READ, 19'h00123, 8'h00, q, e);
    check8(q, 8'h5a);
  endtask

  task automatic t_ident();
    logic [7:0] q;
    logic e;
    do_req(pfc_pkg::PFC_OP_ID_READ, 19'h00000, 8'h00, q, e);
    check8(q, MAKER);
    do_req(pfc_pkg::PFC_OP_ID_READ, 19'h00001, 8'h00, q, e);
    check8(q, PART);
    do_req(pfc_pkg::PFC_OP_ID_EXIT_SHORT, 19'h00000, 8'hf0, q, e);
    do_req(pfc_pkg::PFC_OP_READ, 19'h00123, 8'h00, q, e);
    check8(q, 8'h5a);
    do_req(pfc_pkg::PFC_OP_ID_READ, 19'h00001, 8'h00, q, e);
    do_req(pfc_pkg::PFC_OP_ID_EXIT_LONG, 19'h00000, 8'hf0, q, e);
    do_req(pfc_pkg::PFC_OP_READ, 19'h00123, 8'h00, q, e);
    check8(q, 8'h5a);
  endtask

  task automatic t_sector_erase();
    logic [7:0] q;
    logic e;
    do_req(pfc_pkg::PFC_OP_PROGRAM, 19'h01001, 8'h3c, q, e);
    do_req(pfc_pkg::PFC_OP_PROGRAM, 19'h02001, 8'h11, q, e);
    do_req(pfc_pkg::PFC_OP_SECTOR_ERASE, 19'h01abc, 8'h30, q, e);
    check8({7'h00, e}, 8'h00);
    do_req(pfc_pkg::PFC_OP_READ, 19'h01001, 8'h00, q, e);
    check8(q, 8'hff);
    do_req(pfc_pkg::PFC_OP_READ, 19'h02001, 8'h00, q, e);
    check8(q, 8'h11);
  endtask

  task automatic t_chip_erase();
    logic [7:0] q;
    logic e;
    do_req(pfc_pkg::PFC_OP_CHIP_ERASE, 19'h05555, 8'h10, q, e);
    check8({7'h00, e}, 8'h00);
    do_req(pfc_pkg::PFC_OP_READ, 19'h02001, 8'h00, q, e);
    check8(q, 8'hff);
  endtask

  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    t_program();
    t_ident();
    t_sector_erase();
    t_chip_erase();
    wrap_up();
  end

  initial begin
    #400000;
    num_errors++;
    wrap_up();
  end
endmodule

bind pfc_ctrl pfc_ctrl_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES), .POLL_LIMIT(POLL_LIMIT)) u_chk (.clk(clk),
  .rstn(rstn), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .addr(addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));
